// >>> hw/vic_top.sv
// Vectored interrupt controller: 41 maskable request slots, four levels,
// break software interrupt, reset-source collection, Wishbone registers.
// Assumes request inputs are one-cycle pulses synchronous to clk_i and
// that the CPU core pulses ack, return and break in its own clock.
//
// Overview of operation
// RULE1 - Masking and four levels per source
// RULE2 - Higher level nests over one in service
// RULE3 - Equal levels settle by lowest slot
// RULE4 - Unmasked request raises standby release
// RULE5 - Eight pin and thirty-three internal inputs
// RULE6 - Break vectors 007EH even when disabled
// RULE7 - Break bypasses level arbitration
// RULE8 - Watchdog interval needs option bit 7
// RULE9 - Low voltage interrupts when mode clear
// RULE10 - Low voltage resets when mode set
// RULE11 - Pin edges are maskable, two-byte vectors
// RULE12 - Shared sources share slot and vector
// RULE13 - ADC trigger, comparators at listed vectors
// RULE14 - DMA completions at 001AH, 001CH
// RULE15 - UART errors at 0022H, 0028H
// RULE16 - Timers 0-3 at 002CH-0032H, skip 002AH
// RULE17 - ADC done rank 23 at 0034H
// RULE18 - RTC requests at 0036H and 0038H
// RULE19 - Peak and trough at listed vectors
// RULE20 - Divider done at 0040H
// RULE21 - Timers 4-11 at listed vectors
// RULE22 - All reset sources vector 0000H
// RULE23 - Opcode FFH traps unless emulator
// RULE24 - Acknowledge clears the source flag
// RULE25 - Request flags reset to zero
// RULE26 - Forward only unmasked, enabled, more urgent
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "vic_map.svh"

module vic_top
  import vic_pkg::*;
(
  input  wire logic        clk_i,                      // 125 MHz clock
  input  wire logic        rst_i,                      // Sync reset
  // Wishbone slave
  input  wire logic        wb_cyc_i,                   // Cycle
  input  wire logic        wb_stb_i,                   // Strobe
  input  wire logic        wb_we_i,                    // Write
  input  wire logic [7:0]  wb_adr_i,                   // Byte address
  input  wire logic [3:0]  wb_sel_i,                   // Byte enables
  input  wire logic [31:0] wb_dat_i,                   // Write data
  output logic      [31:0] wb_dat_o,                   // Read data
  output logic             wb_ack_o,                   // Acknowledge
  // Request sources
  input  wire logic [7:0]  pin_edge_i,                 // Pin edge pulses
  input  wire logic [30:0] periph_req_i,               // Internal pulses
  input  wire logic        watchdog_interval_irq_i,    // 75% point pulse
  input  wire logic        low_voltage_detect_i,       // Detector pulse
  input  wire logic        timer_hiz_ctrl_irq0_i,      // Shares pin 3
  input  wire logic        timer_hiz_ctrl_irq1_i,      // Shares pin 7
  input  wire logic        clocked_serial_end_irq00_i, // Shares tx end 0
  input  wire logic        clocked_serial_end_irq01_i, // Shares rx end 0
  input  wire logic        clocked_serial_end_irq10_i, // Shares tx end 1
  input  wire logic        two_wire_end_irq10_i,       // Shares tx end 1
  input  wire logic [7:0]  option_byte_i,              // Option byte
  // Reset sources
  input  wire logic        reset_pin_i,                // Reset pin
  input  wire logic        power_on_clear_i,           // Power-on clear
  input  wire logic        watchdog_overflow_i,        // Watchdog overflow
  input  wire logic        opcode_valid_i,             // Opcode executed
  input  wire logic [7:0]  opcode_i,                   // Executed opcode
  input  wire logic        emulator_i,                 // Debug emulator on
  // CPU core
  input  wire logic        irq_ack_i,                  // Acknowledge
  input  wire logic        irq_return_i,               // Service done
  input  wire logic        software_break_instruction_i, // Break executed
  output logic             irq_o,                      // Request pending
  output logic      [15:0] irq_vector_o,               // Pending vector
  output logic             fetch_valid_o,              // Vector strobe
  output logic      [15:0] fetch_vector_o,             // Vector to fetch
  output logic             reset_req_o,                // Reset request
  output logic             standby_release_o           // Wake from standby
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // RULE13 RULE14 RULE15 RULE16 RULE17 - vector runs
  // RULE18 RULE19 RULE20 RULE21 - gaps skipped
  function automatic vic_vec_t slot_vector(input vic_slot_t s);
    if (s < `VIC_SLOT_B) begin
      return `VIC_VEC_A + {9'h000, s, 1'b0};
    end else if (s < `VIC_SLOT_C) begin
      return `VIC_VEC_B + {9'h000, s - `VIC_SLOT_B, 1'b0};
    end else begin
      return `VIC_VEC_C + {9'h000, s - `VIC_SLOT_C, 1'b0};
    end
  endfunction : slot_vector
  // Current in-service level, 4 when nothing is in service
  function automatic logic [2:0] cur_level(input logic [3:0] isv);
    for (int i = 0; i < 4; i++) begin
      if (isv[i]) begin
        return 3'(i);
      end
    end
    return 3'd4;
  endfunction : cur_level
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge
  // Byte-lane write into the low (31:0) or upper (40:32) word
  function automatic vic_bits_t wr41(input vic_bits_t   old,
                                     input logic        lo,
                                     input logic        hi,
                                     input logic [31:0] wd,
                                     input logic [3:0]  sel);
    logic [31:0] m;
    m = wmerge({23'h0, old[40:32]}, wd, sel);
    return {hi ? m[8:0] : old[40:32],
            lo ? wmerge(old[31:0], wd, sel) : old[31:0]};
  endfunction : wr41
  // Winner search: most urgent level, then lowest slot
  function automatic logic [8:0] arbitrate(input vic_bits_t el,
                                           input vic_bits_t p0,
                                           input vic_bits_t p1);
    logic      found;
    vic_lvl_t  bl;
    vic_slot_t bs;
    found = 1'b0;
    bl = 2'h3;
    bs = 6'h00;
    // Descending scan with <= lets the lower slot win a tie
    for (int i = 40; i >= 0; i--) begin
      if (el[i] && (!found || {p1[i], p0[i]} <= bl)) begin
        found = 1'b1;
        bl = {p1[i], p0[i]};
        bs = 6'(i);
      end
    end
    return {found, bl, bs};
  endfunction : arbitrate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  vic_bits_t   flag_reg,  flag_next;   // Request flags
  vic_bits_t   mask_reg,  mask_next;   // Mask flags, 1 masks
  vic_bits_t   lvl0_reg,  lvl0_next;   // Level flags, low bit
  vic_bits_t   lvl1_reg,  lvl1_next;   // Level flags, high bit
  logic [1:0]  ctrl_reg,  ctrl_next;   // Global enable, low-voltage mode
  logic [3:0]  isv_reg,   isv_next;    // In-service levels
  logic        win_valid_reg;          // Registered winner present
  vic_slot_t   win_slot_reg;           // Registered winner slot
  vic_lvl_t    win_lvl_reg;            // Registered winner level
  vic_vec_t    win_vec_reg;            // Registered winner vector
  logic        fetch_valid_reg;        // Vector strobe
  vic_vec_t    fetch_vec_reg;          // Vector handed to the core
  logic        reset_req_reg;          // Reset request pulse
  logic        wake_reg;               // Standby release level
  logic        ack_reg;                // Wishbone acknowledge
  logic [31:0] rdat_reg;               // Wishbone read data

  // ----------------------------------------------------------------
  // Request collection
  // ----------------------------------------------------------------
  vic_bits_t  set_vec;                 // Hardware set pulses per slot
  wire logic  lv_mode   = ctrl_reg[`VIC_CTRL_LVMODE_BIT];
  wire logic  g_enable  = ctrl_reg[`VIC_CTRL_IE_BIT];
  wire logic  ser_tx1   = clocked_serial_end_irq10_i
                          | two_wire_end_irq10_i;

  // RULE8 - watchdog interval gating
  assign set_vec[0] = watchdog_interval_irq_i
                      & option_byte_i[`VIC_WDT_INT_BIT];
  // RULE9 - low voltage as interrupt
  assign set_vec[1] = low_voltage_detect_i & ~lv_mode;
  // RULE11 - pins 0 to 5; RULE12 - hi-Z 0 shares pin 3
  assign set_vec[7:2] = pin_edge_i[5:0]
                        | {2'b00, timer_hiz_ctrl_irq0_i, 3'b000};
  // RULE5 - internal inputs fill slots 8 to 32
  // RULE12 - serial groups share slots 13, 14 and 16
  assign set_vec[32:8] = periph_req_i[24:0]
                         | {16'h0000, ser_tx1, 1'b0,
                            clocked_serial_end_irq01_i,
                            clocked_serial_end_irq00_i, 5'h00};
  // RULE11 - pin 6; RULE12 - hi-Z 1 shares pin 7
  assign set_vec[33] = pin_edge_i[6];
  assign set_vec[34] = pin_edge_i[7] | timer_hiz_ctrl_irq1_i;
  // RULE5 - remaining internal inputs in slots 35 to 40
  assign set_vec[40:35] = periph_req_i[30:25];

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  wire logic [2:0] svc_lvl = cur_level(isv_reg);
  vic_bits_t       more_urgent;        // Level beats the one in service
  vic_bits_t       eligible;           // Forwardable requests
  logic [8:0]      arb;                // {found, level, slot}

  // RULE1 - each slot level from its flag pair
  // RULE2 - nesting by comparing against service level
  generate
    for (genvar g = 0; g < 41; g++) begin : g_lvl
      assign more_urgent[g] = {1'b0, lvl1_reg[g], lvl0_reg[g]} < svc_lvl;
    end
  endgenerate

  // RULE26 - unmasked, enabled and more urgent only
  assign eligible = flag_reg & ~mask_reg & more_urgent
                    & {41{g_enable}};
  // RULE3 - ties go to the lowest default rank
  assign arb = arbitrate(eligible, lvl0_reg, lvl1_reg);

  // Registered winner is revalidated so a flag cleared by software
  // in the meantime never reaches the core as a stale request
  assign irq_o = win_valid_reg & eligible[win_slot_reg];
  wire logic ack_take = irq_ack_i & irq_o;

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  // RULE23 - illegal opcode trap, not under emulator
  wire logic trap = opcode_valid_i & ~emulator_i
                    & (opcode_i == `VIC_ILLEGAL_OP);
  // RULE10 - low voltage as reset in reset mode
  wire logic lv_reset = low_voltage_detect_i & lv_mode;
  wire logic any_reset = reset_pin_i | power_on_clear_i | lv_reset
                         | watchdog_overflow_i | trap;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire logic        wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic        wb_wr  = wb_req & wb_we_i;
  wire logic        wr_flag_lo = wb_wr & (wb_adr_i == `VIC_OFF_FLAG_LO);
  wire logic        wr_flag_hi = wb_wr & (wb_adr_i == `VIC_OFF_FLAG_HI);
  wire logic        wr_mask_lo = wb_wr & (wb_adr_i == `VIC_OFF_MASK_LO);
  wire logic        wr_mask_hi = wb_wr & (wb_adr_i == `VIC_OFF_MASK_HI);
  wire logic        wr_lvl0_lo = wb_wr & (wb_adr_i == `VIC_OFF_LVL0_LO);
  wire logic        wr_lvl0_hi = wb_wr & (wb_adr_i == `VIC_OFF_LVL0_HI);
  wire logic        wr_lvl1_lo = wb_wr & (wb_adr_i == `VIC_OFF_LVL1_LO);
  wire logic        wr_lvl1_hi = wb_wr & (wb_adr_i == `VIC_OFF_LVL1_HI);
  wire logic        wr_ctrl    = wb_wr & (wb_adr_i == `VIC_OFF_CTRL);

  wire logic [31:0] ctrl_m    = wmerge({30'h0, ctrl_reg},
                                       wb_dat_i, wb_sel_i);

  // Status: winner valid, level, slot, service level, in-service set
  wire logic [31:0] status_w = {16'h0000, win_valid_reg, win_lvl_reg,
                                win_slot_reg, svc_lvl, isv_reg};

  // Read mux; unmapped offsets read as zero and still acknowledge
  logic [31:0] rdata;
  always_comb begin
    case (wb_adr_i)
      `VIC_OFF_FLAG_LO: rdata = flag_reg[31:0];
      `VIC_OFF_FLAG_HI: rdata = {23'h0, flag_reg[40:32]};
      `VIC_OFF_MASK_LO: rdata = mask_reg[31:0];
      `VIC_OFF_MASK_HI: rdata = {23'h0, mask_reg[40:32]};
      `VIC_OFF_LVL0_LO: rdata = lvl0_reg[31:0];
      `VIC_OFF_LVL0_HI: rdata = {23'h0, lvl0_reg[40:32]};
      `VIC_OFF_LVL1_LO: rdata = lvl1_reg[31:0];
      `VIC_OFF_LVL1_HI: rdata = {23'h0, lvl1_reg[40:32]};
      `VIC_OFF_CTRL:    rdata = {30'h0, ctrl_reg};
      `VIC_OFF_STATUS:  rdata = status_w;
      `VIC_OFF_VECTOR:  rdata = {16'h0000, fetch_vec_reg};
      default:          rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  wire vic_bits_t ack_clr = ack_take ? (41'h1 << win_slot_reg) : 41'h0;
  // Flags: software write, then hardware clear, then set on top
  always_comb begin
    flag_next = wr41(flag_reg, wr_flag_lo, wr_flag_hi, wb_dat_i, wb_sel_i);
    // RULE24 - acknowledge clears the flag
    flag_next = flag_next & ~ack_clr;
    // Set wins over any clear in the same cycle
    flag_next = flag_next | set_vec;
  end

  // Mask and level registers are plain software state
  always_comb begin
    mask_next = wr41(mask_reg, wr_mask_lo, wr_mask_hi, wb_dat_i, wb_sel_i);
    lvl0_next = wr41(lvl0_reg, wr_lvl0_lo, wr_lvl0_hi, wb_dat_i, wb_sel_i);
    lvl1_next = wr41(lvl1_reg, wr_lvl1_lo, wr_lvl1_hi, wb_dat_i, wb_sel_i);
    ctrl_next = wr_ctrl ? ctrl_m[1:0] : ctrl_reg;
  end
  // In service: return drops the most urgent, acknowledge adds one
  always_comb begin
    isv_next = isv_reg;
    if (irq_return_i) begin
      isv_next = isv_reg & (isv_reg - 4'h1);
    end
    // RULE2 - nested level enters service
    if (ack_take) begin
      isv_next[win_lvl_reg] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Request, mask, level, control and service state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // RULE25 - flags clear on reset
      flag_reg <= `VIC_FLAG_RST;
      mask_reg <= `VIC_MASK_RST;
      lvl0_reg <= `VIC_LVL_RST;
      lvl1_reg <= `VIC_LVL_RST;
      ctrl_reg <= `VIC_CTRL_RST;
      isv_reg  <= 4'h0;
    end else begin
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      lvl0_reg <= lvl0_next;
      lvl1_reg <= lvl1_next;
      ctrl_reg <= ctrl_next;
      isv_reg  <= isv_next;
    end
  end

  // Winner pipeline stage, cut here to keep the 41-way search short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_valid_reg <= 1'b0;
      win_lvl_reg   <= 2'h3;
      win_slot_reg  <= 6'h00;
      win_vec_reg   <= `VIC_VEC_A;
    end else begin
      win_valid_reg <= arb[8] & ~ack_take;
      win_lvl_reg   <= arb[7:6];
      win_slot_reg  <= arb[5:0];
      // RULE11 - vectors from the slot tables
      win_vec_reg   <= slot_vector(arb[5:0]);
    end
  end

  // Vector handed to the core: reset, then break, then acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_valid_reg <= 1'b0;
      fetch_vec_reg   <= `VIC_VEC_RESET;
      reset_req_reg   <= 1'b0;
    end else begin
      fetch_valid_reg <= any_reset | software_break_instruction_i
                         | ack_take;
      reset_req_reg   <= any_reset;
      if (any_reset) begin
        // RULE22 - common reset vector
        fetch_vec_reg <= `VIC_VEC_RESET;
      end else if (software_break_instruction_i) begin
        // RULE6 - break vector regardless of enable
        // RULE7 - no level check, service state untouched
        fetch_vec_reg <= `VIC_VEC_BRK;
      end else if (ack_take) begin
        fetch_vec_reg <= win_vec_reg;
      end
    end
  end

  // Standby release and Wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      // RULE4 - any unmasked request wakes the core
      wake_reg <= |(flag_reg & ~mask_reg);
      ack_reg  <= wb_req;
      if (wb_req) begin
        rdat_reg <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o          = ack_reg;
  assign wb_dat_o          = rdat_reg;
  assign irq_vector_o      = win_vec_reg;
  assign fetch_valid_o     = fetch_valid_reg;
  assign fetch_vector_o    = fetch_vec_reg;
  assign reset_req_o       = reset_req_reg;
  assign standby_release_o = wake_reg;

endmodule : vic_top

// >>> hw/vic_map.svh
// Constant map of the vectored interrupt controller: register offsets,
// field positions, reset values, vector bases and slot boundaries.
// Assumes inclusion by bare name from the top module.
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

// Wishbone byte offsets, one aligned 32-bit word each
`define VIC_OFF_FLAG_LO 8'h00
`define VIC_OFF_FLAG_HI 8'h04
`define VIC_OFF_MASK_LO 8'h08
`define VIC_OFF_MASK_HI 8'h0c
`define VIC_OFF_LVL0_LO 8'h10
`define VIC_OFF_LVL0_HI 8'h14
`define VIC_OFF_LVL1_LO 8'h18
`define VIC_OFF_LVL1_HI 8'h1c
`define VIC_OFF_CTRL    8'h20
`define VIC_OFF_STATUS  8'h24
`define VIC_OFF_VECTOR  8'h28

// Control register fields
`define VIC_CTRL_IE_BIT    0
`define VIC_CTRL_LVMODE_BIT 1
// Option byte field enabling the watchdog interval request
`define VIC_WDT_INT_BIT    7

// Reset values (request flags clear, everything masked, lowest level)
`define VIC_FLAG_RST 41'h000_0000_0000
`define VIC_MASK_RST 41'h1ff_ffff_ffff
`define VIC_LVL_RST  41'h1ff_ffff_ffff
`define VIC_CTRL_RST 2'h0

// Vector table addresses
`define VIC_VEC_RESET 16'h0000
`define VIC_VEC_BRK   16'h007e
`define VIC_VEC_A     16'h0004
`define VIC_VEC_B     16'h002c
`define VIC_VEC_C     16'h003c

// Slot boundaries of the three contiguous vector runs
`define VIC_SLOT_B 6'd19
`define VIC_SLOT_C 6'd26

// Illegal opcode that traps to reset
`define VIC_ILLEGAL_OP 8'hff

`endif

// >>> hw/vic_pkg.sv
// Types shared by the vectored interrupt controller.
// Assumes the constant map header is on the include path.
package vic_pkg;
  typedef logic [1:0]  vic_lvl_t;   // Programmed level, 0 most urgent
  typedef logic [5:0]  vic_slot_t;  // Request slot, equal to default rank
  typedef logic [15:0] vic_vec_t;   // Vector table address
  typedef logic [40:0] vic_bits_t;  // One bit per request slot
endpackage : vic_pkg

// >>> sim/vic_top_asserts.sv
// Port checker for vic_top: bus answer, vectors, acks, standby.
// Assumes a bind onto vic_top; one clock, sync reset.
`timescale 1ns/1ps
module vic_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        reset_pin_i,
  input wire logic        power_on_clear_i,
  input wire logic        watchdog_overflow_i,
  input wire logic        low_voltage_detect_i,
  input wire logic        opcode_valid_i,
  input wire logic        emulator_i,
  input wire logic        irq_ack_i,
  input wire logic        software_break_instruction_i,
  input wire logic        irq_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic        fetch_valid_o,
  input wire logic [15:0] fetch_vector_o,
  input wire logic        reset_req_o,
  input wire logic        standby_release_o
);
  logic hard;   // Reset pin, power-on clear or watchdog overflow
  logic quiet;  // No reset-like source, so only a break outranks an ack
  assign hard = reset_pin_i | power_on_clear_i | watchdog_overflow_i;
  assign quiet = !(hard | low_voltage_detect_i | opcode_valid_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus access not acked");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack too long");
  brk_vec_a:
    assert property (software_break_instruction_i && quiet
      |=> fetch_valid_o && fetch_vector_o == 16'h007e)
    else $error("Break vector wrong");
  rst_vec_a:
    assert property (hard |=> reset_req_o && fetch_vector_o == 16'h0000)
    else $error("Reset vector wrong");
  emu_trap_a:
    assert property (opcode_valid_i && emulator_i && !hard &&
      !low_voltage_detect_i |=> !reset_req_o)
    else $error("Emulator opcode reset");
  irq_fetch_a:
    assert property (irq_o && irq_ack_i && quiet &&
      !software_break_instruction_i
      |=> fetch_valid_o && fetch_vector_o == $past(irq_vector_o))
    else $error("Ack vector wrong");
  irq_drop_a:
    assert property (irq_o && irq_ack_i |=> !irq_o)
    else $error("Request not cleared");
  standby_on_a:
    assert property (irq_o |-> standby_release_o)
    else $error("No standby release");
endmodule : vic_top_asserts

// >>> sim/vic_cpu_model.sv
// CPU core model: acks a pending request after lat_i cycles and
// returns 17 cycles after the latest ack, then every 16 cycles while any service remains.
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,         // Request pending
  input  wire logic [2:0] lat_i,         // Ack latency
  output logic            ack_o = 1'b0,  // Acknowledge pulse
  output logic            ret_o = 1'b0   // Return pulse
);
  logic [2:0] wait_reg;  // Cycles request seen
  logic [3:0] cnt_reg;   // Service timer
  logic [3:0] deep_reg;  // Nesting depth
  // Long service lets a more urgent request nest meanwhile
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    ret_o <= 1'b0;
    wait_reg <= (irq_i && !ack_o) ? wait_reg + 3'h1 : 3'h0;
    cnt_reg <= cnt_reg + 4'h1;
    if (rst_i) begin
      deep_reg <= 4'h0;
      cnt_reg <= 4'h0;
    end else if (ack_o) begin
      deep_reg <= deep_reg + 4'h1;
      cnt_reg <= 4'h0;
    end else if (deep_reg != 4'h0 && cnt_reg == 4'hf) begin
      ret_o <= 1'b1;
      deep_reg <= deep_reg - 4'h1;
    end
    // One ack per request, only while it is still shown
    if (!rst_i && irq_i && !ack_o && wait_reg >= lat_i) ack_o <= 1'b1;
  end
endmodule : vic_cpu_model

// >>> sim/vic_top_tb_top.sv
// Bench for vic_top with the CPU core model on its far side.
// Assumes 125 MHz clock and a one-cycle bus answer.
`timescale 1ns/1ps
bind vic_top vic_top_asserts chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .reset_pin_i, .power_on_clear_i, .watchdog_overflow_i,
  .low_voltage_detect_i, .opcode_valid_i, .emulator_i, .irq_ack_i,
  .software_break_instruction_i, .irq_o, .irq_vector_o, .fetch_valid_o,
  .fetch_vector_o, .reset_req_o, .standby_release_o);
module vic_top_tb_top;
  import vic_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cs = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, option_byte_i = 8'h00, opcode_i = 8'hff;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, irq_o, fetch_valid_o, reset_req_o;
  logic        standby_release_o, ack, ret, emulator_i = 1'b0, software_break_instruction = 1'b0;
  logic [15:0] irq_vector_o, fetch_vector_o;
  vic_bits_t   src = '0;      // One pulse bit per slot
  logic [5:0]  al = 6'h0;     // Sources sharing a slot
  logic [3:0]  rsv = 4'h0;    // Reset sources
  logic [2:0]  lat = 3'h0;    // CPU ack latency
  int          failures = 0, tests_run = 0, a, b, i;
  int          as[6] = '{5, 13, 14, 16, 16, 34};
  vic_top DUT (.clk_i, .rst_i, .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .pin_edge_i({src[34:33], src[7:2]}),
    .periph_req_i({src[40:35], src[32:8]}),
    .watchdog_interval_irq_i(src[0]), .low_voltage_detect_i(src[1]),
    .timer_hiz_ctrl_irq0_i(al[0]), .clocked_serial_end_irq00_i(al[1]),
    .clocked_serial_end_irq01_i(al[2]), .clocked_serial_end_irq10_i(al[3]),
    .two_wire_end_irq10_i(al[4]), .timer_hiz_ctrl_irq1_i(al[5]),
    .option_byte_i, .reset_pin_i(rsv[0]), .power_on_clear_i(rsv[1]),
    .watchdog_overflow_i(rsv[2]), .opcode_valid_i(rsv[3]), .opcode_i,
    .emulator_i, .irq_ack_i(ack), .irq_return_i(ret),
    .software_break_instruction_i(software_break_instruction), .irq_o, .irq_vector_o,
    .fetch_valid_o, .fetch_vector_o, .reset_req_o, .standby_release_o);
  vic_cpu_model cpu (.clk_i, .rst_i, .irq_i(irq_o), .lat_i(lat),
    .ack_o(ack), .ret_o(ret));
  always #4 clk_i = ~clk_i;
  task end_sim;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Vector address of a slot, from the three runs of the table
  function automatic logic [15:0] vec(input int s);
    if (s < 19) return 16'h0004 + 16'(2 * s);
    if (s < 26) return 16'h002c + 16'(2 * (s - 19));
    return 16'h003c + 16'(2 * (s - 26));
  endfunction : vec
  // Classic cycle: hold all until ack is seen at an edge
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    cs <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rd = wb_dat_o;
    cs <= 1'b0;
    if (t >= 20) begin
      failures++;
      end_sim();
    end
    @(posedge clk_i);
  endtask : wb
  task wf(input logic [15:0] e, input int n);
    int t;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (fetch_valid_o !== 1'b1 && t < n);
    if (fetch_valid_o !== 1'b1) begin
      failures++;
      end_sim();
    end
    chk({16'h0, fetch_vector_o}, {16'h0, e});
  endtask : wf
  task pl(input vic_bits_t v, input logic [5:0] x);
    src <= v;
    al <= x;
    @(posedge clk_i);
    src <= '0;
    al <= 6'h0;
  endtask : pl
  task rs(input logic [3:0] x);
    rsv <= x;
    @(posedge clk_i);
    rsv <= 4'h0;
  endtask : rs
  initial begin
    void'($urandom(70002));
    lat = 3'($urandom_range(7));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h1ff);
    wb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    // Enabled but masked: nothing reaches the core
    wb(1'b1, 8'h20, 32'h1);
    pl(41'h100, 6'h0);
    repeat (3) @(posedge clk_i);
    chk({30'h0, irq_o, standby_release_o}, 32'h0);
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    wf(vec(8), 50);
    // Global enable off: wake only, break still taken
    wb(1'b1, 8'h20, 32'h0);
    pl(41'h200, 6'h0);
    repeat (3) @(posedge clk_i);
    chk({30'h0, irq_o, standby_release_o}, 32'h1);
    software_break_instruction <= 1'b1;
    @(posedge clk_i);
    software_break_instruction <= 1'b0;
    wf(16'h007e, 50);
    wb(1'b1, 8'h20, 32'h1);
    wf(vec(9), 50);
    pl(41'h1, 6'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, standby_release_o}, 32'h0);
    option_byte_i <= 8'h80;
    for (i = 0; i < 41; i++) begin
      pl(41'h1 << i, 6'h0);
      wf(vec(i), 50);
    end
    for (i = 0; i < 6; i++) begin
      pl(41'h0, 6'h1 << i);
      wf(vec(as[i]), 50);
    end
    a = $urandom_range(20);
    b = a + 1 + $urandom_range(10);
    pl((41'h1 << a) | (41'h1 << b), 6'h0);
    wf(vec(a), 50);
    wf(vec(b), 50);
    wb(1'b1, 8'h10, ~(32'h1 << b));
    wb(1'b1, 8'h18, ~(32'h1 << b));
    pl((41'h1 << a) | (41'h1 << b), 6'h0);
    wf(vec(b), 50);
    wf(vec(a), 50);
    // Urgent request must nest before the long service ends
    pl(41'h1 << a, 6'h0);
    wf(vec(a), 50);
    pl(41'h1 << b, 6'h0);
    wf(vec(b), 13);
    for (i = 0; i < 4; i++) begin
      rs(4'h1 << i);
      wf(16'h0000, 50);
      chk({31'h0, reset_req_o}, 32'h1);
    end
    for (i = 0; i < 2; i++) begin
      emulator_i <= (i == 0);
      opcode_i <= (i == 0) ? 8'hff : 8'($urandom_range(254));
      rs(4'h8);
      @(posedge clk_i);
      chk({31'h0, reset_req_o}, 32'h0);
    end
    wb(1'b1, 8'h20, 32'h3);
    pl(41'h2, 6'h0);
    wf(16'h0000, 50);
    end_sim();
  end
endmodule : vic_top_tb_top
